//--- common/pds_consts.svh
// timing counts, register offsets and field positions of the pulse dialling sequencer
// How it works
// [R1] cabled power: wait ten, then ten-tick prepulse
// [R2] contact power: entry period, then raise mute
// [R3] stored keycode: raise mute, time inter-digit pause
// [R4] pause over: digit active, load keycode count
// [R5] digit done: drop active, advance read pointer
// [R6] pointers equal: drop mute, conversation mode
// [R7] enable low past reset delay: standby
// [R8] pause request stops train after digit
// [R9] keycodes still stored during pause request
// [R10] request released: full pause before resuming
// [R11] far side raises, then lowers pause request
// [R12] gated output is pulse AND mute, or the prepulse
// [R13] inter-digit pause is eight pulse periods
// [R14] break three fifths, make two fifths
// [R15] rate select picks normal or test clock
// [R16] digits one to nine, zero gives ten
// [R17] line made whenever no digit active
`ifndef PDS_CONSTS_SVH
`define PDS_CONSTS_SVH

`define PDS_CLK_PERIOD_NS 10
`define PDS_TDP_NORMAL_NS 98700000
`define PDS_TDP_TEST_NS 1073000
`define PDS_TICKS_PER_TDP 30
`define PDS_TICK_NORMAL_CYC (`PDS_TDP_NORMAL_NS / (`PDS_CLK_PERIOD_NS * `PDS_TICKS_PER_TDP))
`define PDS_TICK_TEST_CYC (`PDS_TDP_TEST_NS / (`PDS_CLK_PERIOD_NS * `PDS_TICKS_PER_TDP))
`define PDS_STARTUP_NS 4000000
`define PDS_STARTUP_CYC (`PDS_STARTUP_NS / `PDS_CLK_PERIOD_NS)

`define PDS_PRE_WAIT_TICKS 19'd10
`define PDS_PREPULSE_TICKS 19'd10
`define PDS_ENTRY_TICKS 19'd4
`define PDS_PAUSE_TICKS 19'd240
`define PDS_BREAK_TICKS 19'd18
`define PDS_MAKE_TICKS 19'd12
`define PDS_RESET_DELAY_TICKS 6'd48

`define PDS_ADR_CTRL 8'h00
`define PDS_ADR_KEY 8'h04
`define PDS_ADR_STATUS 8'h08

`define PDS_CTRL_NEW_CALL 0
`define PDS_CTRL_REDIAL 1
`define PDS_ST_MUTE 0
`define PDS_ST_DIGIT 1
`define PDS_ST_PULSE 2
`define PDS_ST_HOLD 3
`define PDS_ST_STANDBY 4
`define PDS_ST_FULL 5
`define PDS_ST_RD_LSB 8
`define PDS_ST_WR_LSB 16

`define PDS_RAM_DEPTH 23
`define PDS_RST_PTR 5'h00

`endif

//--- common/pds_pkg.sv
// types of the pulse dialling sequencer
package pds_pkg;
  typedef enum logic [3:0] {
    PDS_STANDBY,
    PDS_STARTUP,
    PDS_PRE_WAIT,
    PDS_PREPULSE,
    PDS_ENTRY,
    PDS_IDLE,
    PDS_PAUSE,
    PDS_BREAK,
    PDS_MAKE,
    PDS_HOLD
  } pds_state_t;
  typedef logic [3:0] pds_key_t;
endpackage : pds_pkg

//--- verilog/pds_keycode_ram.sv
// keycode store with registered read data
`timescale 1ns/1ps
`default_nettype none
module pds_keycode_ram #(
  parameter int DEPTH = 23,
  parameter int PTR_W = 5,
  parameter int KEY_W = 4
) (
  // clock
  input wire logic clk_i,
  // write side
  input wire logic we_i,
  input wire logic [PTR_W-1:0] waddr_i,
  input wire logic [KEY_W-1:0] wdata_i,
  // read side
  input wire logic [PTR_W-1:0] raddr_i,
  output logic [KEY_W-1:0] rdata_o
);
  // contents survive reset so that a stored number can be redialled
  logic [KEY_W-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : pds_keycode_ram
`default_nettype wire

//--- verilog/pds_sequencer.sv
// pulse dialling sequencer with wishbone keycode port
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pds_consts.svh"
module pds_sequencer #(
  parameter int TICK_NORMAL = `PDS_TICK_NORMAL_CYC,
  parameter int TICK_TEST = `PDS_TICK_TEST_CYC,
  parameter int STARTUP_CYC = `PDS_STARTUP_CYC,
  parameter int DEPTH = `PDS_RAM_DEPTH,
  parameter int PTR_W = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic chip_enable_i,
  input wire logic hold_i,
  input wire logic rate_select_in_i,
  input wire logic contact_supply_i,
  output logic line_pulse_out_o,
  output logic mute_out_o,
  output logic mute_out_n_o,
  output logic gated_pulse_out_o
);
  import pds_pkg::*;

  // pin synchronisers: bit0 enable, bit1 hold, bit2 rate, bit3 contact
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {contact_supply_i, rate_select_in_i, hold_i, chip_enable_i};
      pin_sync <= pin_meta;
    end
  end
  logic ce_s;
  logic hold_s;
  logic rate_s;
  logic contact_s;
  assign ce_s = pin_sync[0];
  assign hold_s = pin_sync[1];
  assign rate_s = pin_sync[2];
  assign contact_s = pin_sync[3];

  function automatic logic [PTR_W-1:0] fn_ptr_inc(input logic [PTR_W-1:0] p);
    fn_ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction : fn_ptr_inc

  function automatic logic fn_done(input logic [18:0] t, input logic [18:0] n, input logic tk);
    fn_done = tk && (t == n - 19'd1);
  endfunction : fn_done

  function automatic logic [3:0] fn_pulses(input pds_key_t k);
    if (k == 4'h0) begin
      fn_pulses = 4'ha; // [R16]
    end else if (k <= 4'h9) begin
      fn_pulses = k; // [R16]
    end else begin
      fn_pulses = 4'h0;
    end
  endfunction : fn_pulses

  // system tick: one thirtieth of a dialling pulse period
  logic [18:0] tick_cnt;
  logic [18:0] next_tick_cnt;
  logic [18:0] tick_lim;
  logic tick;
  always_comb begin
    tick_lim = rate_s ? 19'(TICK_TEST - 1) : 19'(TICK_NORMAL - 1); // [R15]
    // >= keeps the divider sane when rate select rises mid-count
    tick = (tick_cnt >= tick_lim);
    next_tick_cnt = tick ? 19'h0 : tick_cnt + 19'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 19'h0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // wishbone decode
  logic fifo_full;
  logic fifo_empty;
  logic wb_hit;
  logic key_wr;
  logic ctrl_wr;
  logic next_ack;
  logic [31:0] next_dat;
  logic [31:0] status;
  pds_state_t state;
  logic mute;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W-1:0] wr_ptr;
  always_comb begin
    wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // a keycode write waits for buffer room instead of being dropped
    next_ack = wb_hit && !(wb_we_i && wb_adr_i == `PDS_ADR_KEY && fifo_full);
    key_wr = next_ack && wb_we_i && wb_adr_i == `PDS_ADR_KEY && wb_sel_i[0];
    ctrl_wr = next_ack && wb_we_i && wb_adr_i == `PDS_ADR_CTRL && wb_sel_i[0];
    status = 32'h0;
    status[`PDS_ST_MUTE] = mute;
    status[`PDS_ST_DIGIT] = (state == PDS_BREAK) || (state == PDS_MAKE);
    status[`PDS_ST_PULSE] = line_pulse_out_o;
    status[`PDS_ST_HOLD] = (state == PDS_HOLD);
    status[`PDS_ST_STANDBY] = (state == PDS_STANDBY);
    status[`PDS_ST_FULL] = fifo_full;
    status[`PDS_ST_RD_LSB +: PTR_W] = rd_ptr;
    status[`PDS_ST_WR_LSB +: PTR_W] = wr_ptr;
    next_dat = 32'h0;
    if (next_ack && !wb_we_i && wb_adr_i == `PDS_ADR_STATUS) begin
      next_dat = status;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  logic new_call;
  logic redial;
  assign new_call = ctrl_wr && wb_dat_i[`PDS_CTRL_NEW_CALL];
  assign redial = ctrl_wr && wb_dat_i[`PDS_CTRL_REDIAL];

  // two-entry keycode buffer and ram writer
  pds_key_t fifo_q0;
  pds_key_t fifo_q1;
  logic [1:0] fifo_cnt;
  pds_key_t next_q0;
  pds_key_t next_q1;
  logic [1:0] next_fifo_cnt;
  logic [PTR_W-1:0] next_wr_ptr;
  logic ram_we;
  always_comb begin
    fifo_full = (fifo_cnt == 2'd2);
    fifo_empty = (fifo_cnt == 2'd0);
    // entries are stored even under a pause request; only standby or a low enable blocks them
    ram_we = !fifo_empty && ce_s && (state != PDS_STANDBY); // [R9]
    next_q0 = fifo_q0;
    next_q1 = fifo_q1;
    next_fifo_cnt = fifo_cnt;
    next_wr_ptr = wr_ptr;
    if (ram_we) begin
      next_q0 = fifo_q1;
      next_wr_ptr = fn_ptr_inc(wr_ptr);
    end
    case ({key_wr, ram_we})
      2'b10: begin
        if (fifo_cnt == 2'd0) begin
          next_q0 = wb_dat_i[3:0];
        end else begin
          next_q1 = wb_dat_i[3:0];
        end
        next_fifo_cnt = fifo_cnt + 2'd1;
      end
      2'b01: begin
        next_fifo_cnt = fifo_cnt - 2'd1;
      end
      2'b11: begin
        if (fifo_cnt == 2'd1) begin
          next_q0 = wb_dat_i[3:0];
        end else begin
          next_q1 = wb_dat_i[3:0];
        end
      end
      default: begin
        next_fifo_cnt = fifo_cnt;
      end
    endcase
    if (new_call) begin
      next_wr_ptr = `PDS_RST_PTR;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_q0 <= 4'h0;
      fifo_q1 <= 4'h0;
      fifo_cnt <= 2'd0;
      wr_ptr <= `PDS_RST_PTR;
    end else begin
      fifo_q0 <= next_q0;
      fifo_q1 <= next_q1;
      fifo_cnt <= next_fifo_cnt;
      wr_ptr <= next_wr_ptr;
    end
  end

  pds_key_t ram_rdata;
  pds_keycode_ram #(
    .DEPTH(DEPTH),
    .PTR_W(PTR_W),
    .KEY_W(4)
  ) u_ram (
    .clk_i(clk_i),
    .we_i(ram_we),
    .waddr_i(wr_ptr),
    .wdata_i(fifo_q0),
    .raddr_i(rd_ptr),
    .rdata_o(ram_rdata)
  );

  // dialling sequencer
  pds_state_t next_state;
  logic [18:0] timer;
  logic [18:0] next_timer;
  logic [3:0] pulses;
  logic [3:0] next_pulses;
  logic [PTR_W-1:0] next_rd_ptr;
  logic next_mute;
  logic [5:0] ce_low;
  logic [5:0] next_ce_low;
  logic pend;
  always_comb begin
    next_state = state;
    next_timer = tick ? timer + 19'd1 : timer;
    next_pulses = pulses;
    next_rd_ptr = rd_ptr;
    next_mute = mute;
    next_ce_low = ce_s ? 6'd0 : ce_low;
    pend = (rd_ptr != wr_ptr);
    case (state)
      PDS_STANDBY: begin
        next_mute = 1'b0;
        next_rd_ptr = wr_ptr;
        if (ce_s) begin
          next_state = PDS_STARTUP;
          next_timer = 19'd0;
        end
      end
      PDS_STARTUP: begin
        // oscillator start-up is counted in plain cycles
        next_timer = timer + 19'd1;
        if (timer == 19'(STARTUP_CYC - 1)) begin
          next_state = contact_s ? PDS_ENTRY : PDS_PRE_WAIT;
          next_timer = 19'd0;
        end
      end
      PDS_PRE_WAIT: begin
        if (fn_done(timer, `PDS_PRE_WAIT_TICKS, tick)) begin // [R1]
          next_state = PDS_PREPULSE;
          next_timer = 19'd0;
          next_mute = 1'b1; // [R1]
        end
      end
      PDS_PREPULSE: begin
        if (fn_done(timer, `PDS_PREPULSE_TICKS, tick)) begin // [R1]
          next_state = PDS_IDLE;
          next_mute = 1'b0;
        end
      end
      PDS_ENTRY: begin
        if (fn_done(timer, `PDS_ENTRY_TICKS, tick)) begin
          next_mute = 1'b1; // [R2]
          next_state = PDS_PAUSE;
          next_timer = 19'd0;
        end
      end
      PDS_IDLE: begin
        if (pend && !hold_s) begin
          next_mute = 1'b1; // [R3]
          next_state = PDS_PAUSE;
          next_timer = 19'd0;
        end else if (pend) begin
          next_mute = 1'b1;
          next_state = PDS_HOLD; // [R8]
        end
      end
      PDS_PAUSE: begin
        if (fn_done(timer, `PDS_PAUSE_TICKS, tick)) begin // [R13]
          next_timer = 19'd0;
          if (hold_s) begin
            next_state = PDS_HOLD; // [R8]
          end else if (!pend) begin
            next_state = PDS_IDLE;
            next_mute = 1'b0; // [R6]
          end else if (fn_pulses(ram_rdata) == 4'h0) begin
            next_rd_ptr = fn_ptr_inc(rd_ptr);
          end else begin
            next_pulses = fn_pulses(ram_rdata); // [R4]
            next_state = PDS_BREAK; // [R4]
          end
        end
      end
      PDS_BREAK: begin
        if (fn_done(timer, `PDS_BREAK_TICKS, tick)) begin // [R14]
          next_state = PDS_MAKE;
          next_timer = 19'd0;
        end
      end
      PDS_MAKE: begin
        if (fn_done(timer, `PDS_MAKE_TICKS, tick)) begin // [R14]
          next_timer = 19'd0;
          next_pulses = pulses - 4'd1;
          if (pulses == 4'd1) begin
            next_rd_ptr = fn_ptr_inc(rd_ptr); // [R5]
            if (hold_s) begin
              next_state = PDS_HOLD; // [R8]
            end else if (fn_ptr_inc(rd_ptr) != wr_ptr) begin
              next_state = PDS_PAUSE; // [R5]
            end else begin
              next_state = PDS_IDLE;
              next_mute = 1'b0; // [R6]
            end
          end else begin
            next_state = PDS_BREAK;
          end
        end
      end
      PDS_HOLD: begin
        if (!hold_s) begin
          next_state = PDS_PAUSE; // [R10]
          next_timer = 19'd0;
        end
      end
      default: begin
        next_state = PDS_STANDBY;
      end
    endcase
    if (redial) begin
      next_rd_ptr = `PDS_RST_PTR;
    end
    if (new_call) begin
      next_rd_ptr = `PDS_RST_PTR;
    end
    // short enable dips are ridden out; a long one ends the call
    if (!ce_s && state != PDS_STANDBY && tick) begin
      next_ce_low = ce_low + 6'd1;
      if (ce_low == `PDS_RESET_DELAY_TICKS - 6'd1) begin
        next_state = PDS_STANDBY; // [R7]
        next_mute = 1'b0;
        next_ce_low = 6'd0;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= PDS_STANDBY;
      timer <= 19'd0;
      pulses <= 4'd0;
      rd_ptr <= `PDS_RST_PTR;
      mute <= 1'b0;
      ce_low <= 6'd0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      pulses <= next_pulses;
      rd_ptr <= next_rd_ptr;
      mute <= next_mute;
      ce_low <= next_ce_low;
    end
  end

  // pin outputs, registered
  logic next_line;
  logic next_gated;
  always_comb begin
    next_line = (next_state == PDS_BREAK); // [R17]
    // the prepulse also reaches the gated pin so a bistable relay de-mutes
    next_gated = (next_line && next_mute) || (next_state == PDS_PREPULSE); // [R12]
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_pulse_out_o <= 1'b0;
      mute_out_o <= 1'b0;
      mute_out_n_o <= 1'b1;
      gated_pulse_out_o <= 1'b0;
    end else begin
      line_pulse_out_o <= next_line;
      mute_out_o <= next_mute;
      mute_out_n_o <= !next_mute;
      gated_pulse_out_o <= next_gated;
    end
  end
endmodule : pds_sequencer
`default_nettype wire

//--- verification/pds_sequencer_sva.sv
// checker on the sequencer pins and bus
`timescale 1ns/1ps
`default_nettype none
module pds_sequencer_sva #(
  parameter int TICK_NORMAL = 4,
  parameter int TICK_TEST = 3
) (
  // bus
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // pins
  input wire logic chip_enable_i, hold_i, line_pulse_out_o, mute_out_o,
  input wire logic mute_out_n_o, gated_pulse_out_o
);
  // tick edges run free, so lengths may be a tick short
  int hi, lo, ce, hd, rel;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi <= 0; lo <= 0; ce <= 0; hd <= 0; rel <= 0;
    end else begin
      hi <= line_pulse_out_o ? hi + 1 : 0;
      lo <= (line_pulse_out_o || !mute_out_o) ? 0 : lo + 1;
      ce <= chip_enable_i ? 0 : ce + 1;
      hd <= hold_i ? hd + 1 : 0;
      rel <= hold_i ? 0 : (rel != 0 || $fell(hold_i)) ? rel + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  property p_read_ack; s_req ##0 !wb_we_i |=> wb_ack_o; endproperty
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_gated;
    (gated_pulse_out_o |-> mute_out_o) and (line_pulse_out_o |-> gated_pulse_out_o);
  endproperty
  property p_mute_n; mute_out_n_o != mute_out_o; endproperty
  property p_made; line_pulse_out_o |-> mute_out_o; endproperty
  property p_break;
    $fell(line_pulse_out_o) |-> hi >= 17 * TICK_TEST && hi <= 18 * TICK_NORMAL;
  endproperty
  property p_gap;
    $rose(line_pulse_out_o) |-> lo >= 239 * TICK_TEST
      || (lo >= 11 * TICK_TEST && lo <= 12 * TICK_NORMAL);
  endproperty
  property p_hold; hd > 302 * TICK_NORMAL + 4 |-> !line_pulse_out_o; endproperty
  property p_release; rel != 0 && rel < 238 * TICK_TEST |-> !line_pulse_out_o; endproperty
  property p_standby; ce > 50 * TICK_NORMAL + 4 |-> !mute_out_o && !line_pulse_out_o; endproperty
  a_read_ack: assert property (p_read_ack) else $error("read not answered");
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  a_gated: assert property (p_gated) else $error("gated output wrong");
  a_mute_n: assert property (p_mute_n) else $error("mute pair equal");
  a_made: assert property (p_made) else $error("break while unmuted");
  a_break: assert property (p_break) else $error("break length");
  a_gap: assert property (p_gap) else $error("make or pause length");
  a_hold: assert property (p_hold) else $error("pulsing in hold");
  a_release: assert property (p_release) else $error("early resume");
  a_standby: assert property (p_standby) else $error("no standby");
endmodule : pds_sequencer_sva
`default_nettype wire

//--- verification/pds_line_model.sv
// line switch, muting relay and hold equipment
`timescale 1ns/1ps
`default_nettype none
module pds_line_model (
  input wire logic clk_i, rst_i, line_i, mute_i, gated_i, hold_cmd_i,
  output logic hold_o
);
  int cur, lo;
  int digits[$];
  logic relay_muted;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cur <= 0; lo <= 0; relay_muted <= 1'b1; hold_o <= 1'b0;
    end else begin
      hold_o <= hold_cmd_i; // raised and lowered only on command
      // a gated pulse with the loop made flips the bistable relay to speech
      if (gated_i && !line_i) relay_muted <= 1'b0;
      // only breaks sent while muted count as dial pulses
      if (line_i && !$past(line_i) && mute_i) cur <= cur + 1;
      lo <= line_i ? 0 : lo + 1;
      if (lo == 200 && cur != 0) begin
        digits.push_back(cur);
        cur <= 0;
      end
    end
  end
endmodule : pds_line_model
`default_nettype wire

//--- verification/pds_sequencer_bench.sv
// self-checking bench of the pulse dialling sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %0h want %0h", $time, a, b); end end
module pds_sequencer_bench;
  logic clk_i, rst_i, cyc, stb, we, ce, rate, contact, hold_cmd, hold, line, mute, gated, mute_n;
  logic wb_ack_o;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] dat, q, wb_dat_o, seed;
  int fail_count, comparisons, wp, n;
  int exp_q[$], hist[$];
  pds_sequencer #(.TICK_NORMAL(4), .TICK_TEST(3), .STARTUP_CYC(5)) u_pds_sequencer (
    .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .chip_enable_i(ce),
    .hold_i(hold), .rate_select_in_i(rate), .contact_supply_i(contact),
    .line_pulse_out_o(line), .mute_out_o(mute), .mute_out_n_o(mute_n), .gated_pulse_out_o(gated));
  pds_line_model u_line (.clk_i, .rst_i, .line_i(line), .mute_i(mute), .gated_i(gated),
    .hold_cmd_i(hold_cmd), .hold_o(hold));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task final_report;
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // one classic cycle; a full keycode buffer stretches the wait
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 50000);
    if (k >= 50000) begin fail_count++; final_report(); end
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : bus
  task key(input int k);
    bus(1'b1, 8'h04, 32'(k));
    wp = (wp + 1) % 23;
    hist.push_back(k);
    if (k <= 9) exp_q.push_back(k == 0 ? 10 : k);
  endtask : key
  task till(input bit s, input logic v, input int bound);
    n = 0;
    while ((s ? line : mute) !== v) begin
      @(posedge clk_i);
      n++;
      if (n > bound) begin fail_count++; final_report(); end
    end
  endtask : till
  // the model closes a digit only after 200 quiet cycles
  task drain;
    int g, e;
    till(0, 1'b1, 100);
    till(0, 1'b0, 40000);
    repeat (250) @(posedge clk_i);
    `CHK(u_line.digits.size(), exp_q.size())
    while (exp_q.size() > 0 && u_line.digits.size() > 0) begin
      g = u_line.digits.pop_front();
      e = exp_q.pop_front();
      `CHK(g, e)
    end
    exp_q.delete();
  endtask : drain
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; ce = 1; rate = 1;
    contact = 0; hold_cmd = 0; fail_count = 0; comparisons = 0; wp = 0; seed = 32'ha1fb;
    sel = 4'hf;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    till(0, 1'b1, 2000);
    `CHK(gated & ~line & ~mute_n, 1'b1)
    till(0, 1'b0, 100);
    `CHK(n >= 27 && n <= 33, 1'b1)
    `CHK(u_line.relay_muted, 1'b0)
    repeat (5) begin
      seed = lfsr(seed);
      key(int'(seed[3:0]));
    end
    key(0);
    key(12);
    drain();
    bus(1'b0, 8'h08, 0);
    `CHK(q[12:8], 5'(wp))
    `CHK(q[1:0], 2'b00)
    key(2);
    key(3);
    till(1, 1'b1, 2000);
    hold_cmd <= 1'b1;
    key(5);
    repeat (1300) @(posedge clk_i);
    bus(1'b0, 8'h08, 0);
    `CHK(u_line.digits.size(), 1)
    `CHK(q[20:16], 5'(wp))
    `CHK(q[12:8], 5'((wp + 21) % 23))
    `CHK({q[3], line}, 2'b10)
    hold_cmd <= 1'b0;
    drain();
    rate <= 1'b0;
    key(1);
    till(0, 1'b1, 100);
    till(1, 1'b1, 2000);
    `CHK(n >= 955 && n <= 966, 1'b1)
    till(1, 1'b0, 200);
    `CHK(n >= 68 && n <= 73, 1'b1)
    drain();
    rate <= 1'b1;
    // redial sends the whole stored number again from the first location
    bus(1'b1, 8'h00, 32'h2);
    foreach (hist[i]) if (hist[i] <= 9) exp_q.push_back(hist[i] == 0 ? 10 : hist[i]);
    drain();
    key(7);
    till(0, 1'b1, 100);
    ce <= 1'b0;
    till(0, 1'b0, 400);
    `CHK(n >= 141, 1'b1)
    bus(1'b0, 8'h08, 0);
    `CHK({q[4], q[12:8]}, {1'b1, q[20:16]})
    repeat (100) @(posedge clk_i);
    ce <= 1'b1;
    bus(1'b1, 8'h00, 1);
    // a keycode write without lane 0 must leave the store untouched
    sel <= 4'he;
    bus(1'b1, 8'h04, 32'h3);
    sel <= 4'hf;
    bus(1'b0, 8'h08, 0);
    `CHK(q[20:8], 13'h0)
    bus(1'b0, 8'h3c, 0);
    `CHK(q, 32'h0)
    contact <= 1'b1;
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    till(0, 1'b1, 200);
    `CHK(gated, 1'b0)
    final_report();
  end
endmodule : pds_sequencer_bench
bind pds_sequencer pds_sequencer_sva #(.TICK_NORMAL(TICK_NORMAL), .TICK_TEST(TICK_TEST)) u_sva (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_dat_o, .chip_enable_i,
  .hold_i, .line_pulse_out_o, .mute_out_o, .mute_out_n_o, .gated_pulse_out_o);
`default_nettype wire
